//--- core/lfb_bucket.sv
// Chosen here: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
module lfb_bucket
    import lfb_pkg::*;
#(
    parameter int EVAL_CYC = LFB_EVAL_CYC
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        fault_in,
    output logic             alarm
);
    typedef enum logic [0:0] {LFB_IDLE = 1'b0, LFB_DATA = 1'b1} lfb_bus_t;

    lfb_bus_t    bus_reg,   bus_next;
    logic [7:0]  addr_reg,  addr_next;
    logic        wr_reg,    wr_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [7:0]  raise_reg, raise_next;
    logic [7:0]  clear_reg, clear_next;
    logic [1:0]  decay_reg, decay_next;
    logic [31:0] tick_reg,  tick_next;
    logic        seen_reg,  seen_next;
    logic [3:0]  clean_reg, clean_next;
    logic [7:0]  count_reg, count_next;
    logic        alarm_reg, alarm_next;
    logic        tick;
    logic        cyc_fault;
    logic [3:0]  clean_len;

    // Read word of one register; the values come in as arguments so that a
    // read right behind a write can be handed the freshly written level
    function automatic logic [31:0] rd_mux(
        input logic [7:0] a,
        input logic [7:0] raise_v,
        input logic [7:0] clear_v,
        input logic [1:0] decay_v,
        input logic       alarm_v,
        input logic [7:0] count_v
    );
        logic [31:0] w;
        w = 32'h00000000;
        case (a)
            LFB_RAISE_OFS: w[7:0] = raise_v;
            LFB_CLEAR_OFS: w[7:0] = clear_v;
            LFB_DECAY_OFS: w[1:0] = decay_v;
            LFB_STAT_OFS: begin
                w[LFB_STAT_COUNT_LSB +: 8] = count_v;
                w[LFB_STAT_ALARM_BIT]      = alarm_v;
            end
            default: w = 32'h00000000;
        endcase
        return w;
    endfunction

    // A transfer starts when this slave is selected while the bus is ready;
    // IDLE and BUSY carry nothing and are ignored
    function automatic logic bus_start(
        input logic       sel,
        input logic       rdy,
        input logic [1:0] trans
    );
        return sel && rdy && (trans == LFB_HTRANS_NONSEQ || trans == LFB_HTRANS_SEQ);
    endfunction

    // Word address; the byte lanes below it are ignored, as hsize is
    function automatic logic [7:0] word_addr(input logic [7:0] a);
        return {a[7:2], 2'b00};
    endfunction

    // Zero-wait slave: every transfer completes in its first data cycle
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_reg;
    assign alarm     = alarm_reg;

    // Bus phase tracking: an address phase is latched and acted on one cycle later
    always_comb begin
        bus_next  = LFB_IDLE;
        addr_next = addr_reg;
        wr_next   = 1'b0;
        if (bus_start(hsel, hready, htrans)) begin
            bus_next  = LFB_DATA;
            addr_next = word_addr(haddr);
            wr_next   = hwrite;
        end
    end

    // Bus phase registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_reg  <= LFB_IDLE;
            addr_reg <= 8'h00;
            wr_reg   <= 1'b0;
        end else begin
            bus_reg  <= bus_next;
            addr_reg <= addr_next;
            wr_reg   <= wr_next;
        end
    end

    // Register writes land at the end of the data phase, while hwdata stands
    always_comb begin
        raise_next = raise_reg;
        clear_next = clear_reg;
        decay_next = decay_reg;
        case (bus_reg)
            LFB_DATA: begin
                if (wr_reg) begin
                    case (addr_reg)
                        LFB_RAISE_OFS: raise_next = hwdata[7:0];
                        LFB_CLEAR_OFS: clear_next = hwdata[7:0];
                        LFB_DECAY_OFS: decay_next = hwdata[1:0];
                        default: ;
                    endcase
                end
            end
            default: ;
        endcase
    end

    // Level and decay registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            raise_reg <= LFB_RAISE_RST;
            clear_reg <= LFB_CLEAR_RST;
            decay_reg <= LFB_DECAY_RST;
        end else begin
            raise_reg <= raise_next;
            clear_reg <= clear_next;
            decay_reg <= decay_next;
        end
    end

    // Read data is caught at the address phase edge so that hrdata comes from a
    // flip-flop; the next values let a read see a write that ends at that edge
    always_comb begin
        rdata_next = rdata_reg;
        if (bus_start(hsel, hready, htrans) && !hwrite) begin
            rdata_next = rd_mux(word_addr(haddr), raise_next, clear_next, decay_next,
                                alarm_reg, count_reg);
        end
    end

    // Read data register; it holds until the next read
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_reg <= 32'h00000000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign tick = (tick_reg == 32'(EVAL_CYC - 1));

    // Free-running timer; it never pauses, so evaluation cycles stay evenly spaced
    always_comb begin
        tick_next = tick ? 32'h00000000 : tick_reg + 32'h00000001;
    end

    // Evaluation timer register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_reg <= 32'h00000000;
        end else begin
            tick_reg <= tick_next;
        end
    end

    // A fault in the last clock of a cycle still counts for that cycle
    assign cyc_fault = seen_reg | fault_in;
    // Clean period length in evaluation cycles: 1, 2, 4 or 8
    assign clean_len = 4'h1 << decay_reg;

    // Bucket count; it saturates at both ends instead of wrapping
    always_comb begin
        seen_next  = tick ? 1'b0 : cyc_fault;
        clean_next = clean_reg;
        count_next = count_reg;
        if (tick) begin
            if (cyc_fault) begin
                clean_next = 4'h0;
                if (count_reg != 8'hff) begin
                    count_next = count_reg + 8'h01;
                end
            end else if (clean_reg + 4'h1 >= clean_len) begin
                clean_next = 4'h0;
                if (count_reg != 8'h00) begin
                    count_next = count_reg - 8'h01;
                end
            end else begin
                clean_next = clean_reg + 4'h1;
            end
        end
    end

    // Bucket registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seen_reg  <= 1'b0;
            clean_reg <= 4'h0;
            count_reg <= 8'h00;
        end else begin
            seen_reg  <= seen_next;
            clean_reg <= clean_next;
            count_reg <= count_next;
        end
    end

    // Alarm follows the new count and the new levels together, so a level
    // written by software takes effect in the same edge as its register
    always_comb begin
        alarm_next = alarm_reg;
        if (count_next >= raise_next) begin
            alarm_next = 1'b1;
        end else if (count_next <= clear_next) begin
            alarm_next = 1'b0;
        end
    end

    // Alarm register; raising wins where the two levels overlap
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            alarm_reg <= 1'b0;
        end else begin
            alarm_reg <= alarm_next;
        end
    end

    // Steps of a fault evaluation: the cycle closes with a fault seen
    sequence s_fault_tick;
        tick && cyc_fault;
    endsequence

    // Steps of a clean evaluation: the cycle closes with no fault seen
    sequence s_clean_tick;
        tick && !cyc_fault;
    endsequence

    // A clean evaluation that completes the programmed period
    sequence s_period_end;
        s_clean_tick ##0 (clean_reg + 4'h1 >= clean_len);
    endsequence

    // A read address phase aimed at the clear level
    sequence s_clear_read;
        bus_start(hsel, hready, htrans) && !hwrite && word_addr(haddr) == LFB_CLEAR_OFS;
    endsequence

    a_tick_period: assert property (@(posedge hclk) disable iff (!hresetn)
        tick |=> !tick [*3]) else $error("tick too frequent");
    a_tick_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
        tick |=> tick_reg == 32'h00000000) else $error("timer did not wrap");
    a_seen_cleared: assert property (@(posedge hclk) disable iff (!hresetn)
        tick |=> !seen_reg) else $error("fault flag kept past tick");
    a_fault_incr: assert property (@(posedge hclk) disable iff (!hresetn)
        s_fault_tick ##0 count_reg != 8'hff |=> count_reg == $past(count_reg) + 8'h01)
        else $error("fault did not increment");
    a_fault_sat: assert property (@(posedge hclk) disable iff (!hresetn)
        s_fault_tick ##0 count_reg == 8'hff |=> count_reg == 8'hff) else $error("count wrapped");
    a_no_decr_between: assert property (@(posedge hclk) disable iff (!hresetn)
        !tick |=> count_reg == $past(count_reg)) else $error("count moved off tick");
    a_decr_step: assert property (@(posedge hclk) disable iff (!hresetn)
        s_period_end ##0 count_reg != 8'h00 |=> count_reg == $past(count_reg) - 8'h01)
        else $error("clean period did not decrement");
    a_clean_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        s_clean_tick ##0 (clean_reg + 4'h1 < clean_len) |=> count_reg == $past(count_reg)
        && clean_reg == $past(clean_reg) + 4'h1) else $error("clean period miscounted");
    a_clean_restart: assert property (@(posedge hclk) disable iff (!hresetn)
        s_fault_tick |=> clean_reg == 4'h0) else $error("fault kept clean count");
    a_alarm_raise: assert property (@(posedge hclk) disable iff (!hresetn)
        count_reg >= raise_reg |-> alarm_reg) else $error("alarm not raised");
    a_alarm_rise_cause: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(alarm_reg) |-> count_reg >= raise_reg) else $error("alarm rose early");
    a_alarm_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        count_reg <= clear_reg && count_reg < raise_reg |-> !alarm_reg)
        else $error("alarm not cleared");
    a_alarm_fall_cause: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(alarm_reg) |-> count_reg <= clear_reg) else $error("alarm fell early");
    a_clear_write: assert property (@(posedge hclk) disable iff (!hresetn)
        bus_reg == LFB_DATA && wr_reg && addr_reg == LFB_CLEAR_OFS
        |=> clear_reg == $past(hwdata[7:0])) else $error("clear level not written");
    a_clear_read: assert property (@(posedge hclk) disable iff (!hresetn)
        s_clear_read |=> hrdata == {24'h000000, clear_reg}) else $error("clear level misread");
endmodule

//--- shared/lfb_pkg.sv
package lfb_pkg;
    // Register byte offsets on the bus
    localparam logic [7:0] LFB_RAISE_OFS = 8'h00;
    localparam logic [7:0] LFB_CLEAR_OFS = 8'h04;
    localparam logic [7:0] LFB_DECAY_OFS = 8'h08;
    localparam logic [7:0] LFB_STAT_OFS  = 8'h0c;
    // Reset values
    localparam logic [7:0] LFB_RAISE_RST = 8'h08;
    localparam logic [7:0] LFB_CLEAR_RST = 8'h04;
    localparam logic [1:0] LFB_DECAY_RST = 2'h0;
    // Evaluation cycle timing
    localparam int LFB_CLK_HZ    = 50000000;
    localparam int LFB_EVAL_MS   = 128;
    localparam int LFB_EVAL_CYC  = (LFB_CLK_HZ / 1000) * LFB_EVAL_MS;
    // Status field positions
    localparam int LFB_STAT_ALARM_BIT = 8;
    localparam int LFB_STAT_COUNT_LSB = 0;
    // Bus transfer type
    localparam logic [1:0] LFB_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] LFB_HTRANS_SEQ    = 2'h3;
endpackage

//--- sim/testbench.sv
`timescale 1ns/1ps
module testbench
    import lfb_pkg::*;
;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        fault_in;
    logic        alarm;
    logic [31:0] q;
    logic [7:0]  prev;
    time         t0;
    int          fail_count;
    int          comparisons;
    int          n;
    int          k;
    // Single slave, so its ready is the bus ready
    assign hready = hreadyout;
    // Short evaluation cycle keeps the run brief
    lfb_bucket #(.EVAL_CYC(8)) u_lfb_bucket (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .fault_in(fault_in), .alarm(alarm));
    // 50 MHz clock
    always #10 hclk = ~hclk;
    task automatic complete_run();
        $display("Mismatches %0d of %0d comparisons", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Wait for ready at each phase; a stuck bus ends the run
    task automatic rdy();
        int m;
        m = 0;
        do begin
            @(posedge hclk);
            m++;
        end while (hready !== 1'b1 && m < 50);
        if (m >= 50) begin
            chk(32'h0, 32'h1);
            complete_run();
        end
    endtask
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= LFB_HTRANS_NONSEQ;
        rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rdy();
        q = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask
    task automatic wait_alarm(input logic v);
        n = 0;
        while (alarm !== v && n < 500) begin
            @(posedge hclk);
            n++;
        end
        chk({31'h0, alarm}, {31'h0, v});
        if (n >= 500) complete_run();
    endtask
    initial begin
        {hclk, hsel, haddr, htrans, hwrite, hwdata, fault_in, fail_count, comparisons} = '0;
        hsize = 3'h2;
        hresetn = 1'b0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // Reset values, and an unmapped place reading zero
        xfer(LFB_CLEAR_OFS, 1'b0, 32'h0); chk(q, 32'h4);
        xfer(LFB_RAISE_OFS, 1'b0, 32'h0); chk(q, {24'h0, LFB_RAISE_RST});
        xfer(LFB_STAT_OFS, 1'b0, 32'h0); chk(q, 32'h0);
        xfer(8'h10, 1'b0, 32'h0); chk(q, 32'h0);
        xfer(LFB_CLEAR_OFS, 1'b1, 32'hffff_ffa5);
        xfer(LFB_CLEAR_OFS, 1'b0, 32'h0); chk(q, 32'ha5);
        // Faults climb to raise level 3, clean cycles drain to clear level 2
        xfer(LFB_CLEAR_OFS, 1'b1, 32'h2);
        xfer(LFB_RAISE_OFS, 1'b1, 32'h3);
        fault_in <= 1'b1;
        wait_alarm(1'b1);
        fault_in <= 1'b0;
        xfer(LFB_STAT_OFS, 1'b0, 32'h0); chk(q, 32'h103);
        wait_alarm(1'b0);
        xfer(LFB_STAT_OFS, 1'b0, 32'h0); chk(q, 32'h2);
        // Spacing of decrements for each decay setting; polling costs two clocks
        xfer(LFB_RAISE_OFS, 1'b1, 32'hff);
        for (int d = 0; d < 4; d++) begin
            xfer(LFB_DECAY_OFS, 1'b1, d);
            xfer(LFB_DECAY_OFS, 1'b0, 32'h0); chk(q, d);
            fault_in <= 1'b1;
            repeat (24) @(posedge hclk);
            fault_in <= 1'b0;
            k = 0;
            n = 0;
            prev = 8'hff;
            while (k < 2 && n < 400) begin
                xfer(LFB_STAT_OFS, 1'b0, 32'h0);
                n++;
                if (q[7:0] < prev && prev != 8'hff) begin
                    if (k == 1) chk(32'((($time - t0) + 60) / 40), 32'((8 << d) / 2 + 1));
                    t0 = $time;
                    k++;
                end
                prev = q[7:0];
            end
            if (n >= 400) begin
                chk(32'h0, 32'h1);
                complete_run();
            end
        end
        // Faults held long enough to pin the count at its top, alarm raised there
        fault_in <= 1'b1;
        repeat (2200) @(posedge hclk);
        xfer(LFB_STAT_OFS, 1'b0, 32'h0); chk(q, 32'h1ff);
        fault_in <= 1'b0;
        complete_run();
    end
endmodule
